// file: tsc_map.vh
`ifndef TSC_MAP_VH
`define TSC_MAP_VH
// register indices (byte address = index)
`define TSC_ADDR_SUPPLY   4'h0
`define TSC_ADDR_REGVOLT  4'h1
`define TSC_ADDR_MODDEPTH 4'h2
`define TSC_ADDR_OVPAT_LO 4'h3
`define TSC_ADDR_OVPAT_HI 4'h4
`define TSC_ADDR_OVMODE   4'h5
`define TSC_ADDR_UNPAT_LO 4'h6
`define TSC_ADDR_UNPAT_HI 4'h7
`define TSC_ADDR_DISPLAY  4'h8
// supply register fields
`define TSC_BIT_ENABLE    0
`define TSC_BIT_LOWSUP    1
`define TSC_BIT_DREGOFF   2
// regulator voltage register fields
`define TSC_BIT_REGMANUAL 4
// display fields
`define TSC_BIT_ILIM      4
// fixed analog/logic code in 5 V mode: 3.4 V
`define TSC_CODE_FIXED34  4'hf
// shaping drive modes
`define TSC_MODE_DRSUP    2'h0
`define TSC_MODE_AMREG    2'h1
`define TSC_MODE_PAUSE    2'h2
// pattern length
`define TSC_PAT_LEN       4'he
`define TSC_PAT_ZERO      14'h0000
`define TSC_RESET_BYTE    8'h00
`endif

// file: tsc_shaper.v
`include "tsc_map.vh"
// walks a 14-bit pattern one cycle per bit after a trigger
module tsc_shaper (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // control
    input  wire        trigger,
    input  wire [13:0] pattern,
    input  wire [1:0]  mode,
    // result
    output reg         active,
    output reg  [1:0]  activeMode
);
    reg [3:0] step;
    reg       running;
    reg [1:0] heldMode;

    // step counter restarts on every trigger, idles at zero
    always @(posedge ref_clk) begin
        if (reset) begin
            step     <= 4'h0;
            running  <= 1'b0;
            heldMode <= `TSC_MODE_DRSUP;
        end else if (trigger) begin
            step     <= 4'h1;
            running  <= (pattern != `TSC_PAT_ZERO);
            heldMode <= mode;
        end else if (running && step < `TSC_PAT_LEN - 4'h1) begin
            step     <= step + 4'h1;
        end else begin
            step     <= 4'h0;
            running  <= 1'b0;
        end
    end

    // bit 0 is offered in the trigger cycle so the caller's register lands it in cycle one
    always @* begin
        if (trigger) begin
            active     = pattern[0];
            activeMode = mode;
        end else begin
            active     = running && pattern[step];
            activeMode = heldMode;
        end
    end
endmodule // tsc_shaper

// file: tsc_supply_ctrl.v
`include "tsc_map.vh"
module tsc_supply_ctrl (
    // clock and reset
    input  wire       ref_clk,
    input  wire       reset,
    // register port
    input  wire [3:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdata,
    // adjust-regulators result and analog status
    input  wire       autoValid,
    input  wire [3:0] autoCode,
    input  wire       currentLimit,
    // modulation state from encoder
    input  wire       modulated,
    // regulator controls
    output reg        regEnable,
    output reg        lowSupplyModeSel,
    output reg  [3:0] txRegCode,
    output reg  [3:0] analogRegCode,
    output reg  [3:0] logicRegCode,
    output reg        logicRegEnable,
    output reg        pdSupportEnable,
    output reg  [3:0] modulationDepthCode,
    // driver override
    output reg        driverOverride,
    output reg  [1:0] driverOverrideMode
);
    // configuration storage
    reg        enableBit;
    reg        lowSup;
    reg        dregOff;
    reg        regManual;
    reg [3:0]  manualCode;
    reg [3:0]  autoResult;
    reg [3:0]  depth;
    reg [13:0] ovPattern;
    reg [13:0] unPattern;
    reg [1:0]  ovMode;
    reg [1:0]  unMode;
    reg        modPrev;
    reg        limSync0;
    reg        limSync1;
    wire [3:0] codeInUse = regManual ? manualCode : autoResult;
    wire       ovTrig    = modPrev && !modulated;
    wire       unTrig    = !modPrev && modulated;
    wire       ovAct;
    wire       unAct;
    wire [1:0] ovActMode;
    wire [1:0] unActMode;

    // register writes
    always @(posedge ref_clk) begin
        if (reset) begin
            enableBit  <= 1'b0;
            lowSup     <= 1'b0;
            dregOff    <= 1'b0;
            regManual  <= 1'b0;
            manualCode <= 4'h0;
            depth      <= 4'h0;
            ovPattern  <= `TSC_PAT_ZERO;
            unPattern  <= `TSC_PAT_ZERO;
            ovMode     <= `TSC_MODE_DRSUP;
            unMode     <= `TSC_MODE_DRSUP;
        end else if (regWrite) begin
            case (regAddr)
                `TSC_ADDR_SUPPLY: begin
                    enableBit <= regWdata[`TSC_BIT_ENABLE];
                    lowSup    <= regWdata[`TSC_BIT_LOWSUP];
                    dregOff   <= regWdata[`TSC_BIT_DREGOFF];
                end
                `TSC_ADDR_REGVOLT: begin
                    regManual  <= regWdata[`TSC_BIT_REGMANUAL];
                    manualCode <= regWdata[3:0];
                end
                `TSC_ADDR_MODDEPTH: depth <= regWdata[3:0];
                `TSC_ADDR_OVPAT_LO: ovPattern[7:0] <= regWdata;
                `TSC_ADDR_OVPAT_HI: ovPattern[13:8] <= regWdata[5:0];
                `TSC_ADDR_OVMODE: begin
                    ovMode <= regWdata[1:0];
                    unMode <= regWdata[5:4];
                end
                `TSC_ADDR_UNPAT_LO: unPattern[7:0] <= regWdata;
                `TSC_ADDR_UNPAT_HI: unPattern[13:8] <= regWdata[5:0];
                default: ;
            endcase
        end
    end

    // latch the adjust-regulators result
    always @(posedge ref_clk) begin
        if (reset) begin
            autoResult <= 4'h0;
        end else if (autoValid) begin
            autoResult <= autoCode;
        end
    end

    // current-limit pin synchroniser and carrier edge tracking
    always @(posedge ref_clk) begin
        if (reset) begin
            limSync0 <= 1'b0;
            limSync1 <= 1'b0;
            modPrev  <= 1'b0;
        end else begin
            limSync0 <= currentLimit;
            limSync1 <= limSync0;
            modPrev  <= modulated;
        end
    end

    // regulator outputs
    always @(posedge ref_clk) begin
        if (reset) begin
            regEnable           <= 1'b0;
            lowSupplyModeSel    <= 1'b0;
            txRegCode           <= 4'h0;
            analogRegCode       <= `TSC_CODE_FIXED34;
            logicRegCode        <= `TSC_CODE_FIXED34;
            logicRegEnable      <= 1'b0;
            pdSupportEnable     <= 1'b1;
            modulationDepthCode <= 4'h0;
        end else begin
            regEnable           <= enableBit;
            lowSupplyModeSel    <= lowSup;
            txRegCode           <= codeInUse;
            analogRegCode       <= lowSup ? codeInUse : `TSC_CODE_FIXED34;
            logicRegCode        <= lowSup ? codeInUse : `TSC_CODE_FIXED34;
            logicRegEnable      <= enableBit && !dregOff;
            pdSupportEnable     <= !enableBit && !lowSup;
            modulationDepthCode <= depth;
        end
    end

    // overshoot and undershoot sequencers
    tsc_shaper overShaper (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .trigger    (ovTrig),
        .pattern    (ovPattern),
        .mode       (ovMode),
        .active     (ovAct),
        .activeMode (ovActMode)
    );
    tsc_shaper underShaper (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .trigger    (unTrig),
        .pattern    (unPattern),
        .mode       (unMode),
        .active     (unAct),
        .activeMode (unActMode)
    );

    // driver override: one cycle from each sequencer bit
    always @(posedge ref_clk) begin
        if (reset) begin
            driverOverride     <= 1'b0;
            driverOverrideMode <= `TSC_MODE_DRSUP;
        end else begin
            driverOverride     <= ovAct || unAct;
            driverOverrideMode <= ovAct ? ovActMode : unActMode;
        end
    end

    // read port, data valid the cycle after the strobe
    always @(posedge ref_clk) begin
        if (reset) begin
            regRdata <= `TSC_RESET_BYTE;
        end else if (regRead) begin
            case (regAddr)
                `TSC_ADDR_SUPPLY:   regRdata <= {5'h00, dregOff, lowSup, enableBit};
                `TSC_ADDR_REGVOLT:  regRdata <= {3'h0, regManual, manualCode};
                `TSC_ADDR_MODDEPTH: regRdata <= {4'h0, depth};
                `TSC_ADDR_OVPAT_LO: regRdata <= ovPattern[7:0];
                `TSC_ADDR_OVPAT_HI: regRdata <= {2'h0, ovPattern[13:8]};
                `TSC_ADDR_OVMODE:   regRdata <= {2'h0, unMode, 2'h0, ovMode};
                `TSC_ADDR_UNPAT_LO: regRdata <= unPattern[7:0];
                `TSC_ADDR_UNPAT_HI: regRdata <= {2'h0, unPattern[13:8]};
                `TSC_ADDR_DISPLAY:  regRdata <= {3'h0, limSync1, (enableBit ? codeInUse : 4'h0)};
                default:            regRdata <= `TSC_RESET_BYTE;
            endcase
        end else begin
            regRdata <= `TSC_RESET_BYTE;
        end
    end
endmodule // tsc_supply_ctrl

// file: tsc_analog_model.sv
module tsc_analog_model (
    // test control
    input              ref_clk,
    input              adjReq,
    input        [3:0] adjCode,
    input              limitOn,
    // toward the block
    output logic       autoValid = 1'b0,
    output logic [3:0] autoCode = 4'h0,
    output logic       currentLimit = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] busy = 3'h0;
    // adjust result arrives late, code lines carry junk outside the pulse
    always @(posedge ref_clk) begin
        autoValid <= busy == 3'h1;
        autoCode <= busy == 3'h1 ? adjCode : ~autoCode;
        busy <= adjReq ? 3'h5 : busy - 3'(busy != 3'h0);
    end
    // limiter flag is not aligned to the clock
    always @(limitOn) currentLimit <= #7 limitOn;
endmodule // tsc_analog_model

// file: tsc_supply_ctrl_props.sv
module tsc_props (
    // clock, reset, register writes
    input       ref_clk,
    input       reset,
    input [3:0] regAddr,
    input [7:0] regWdata,
    input       regWrite,
    // watched signals
    input       modulated,
    input       regEnable,
    input       lowSupplyModeSel,
    input [3:0] txRegCode,
    input [3:0] analogRegCode,
    input [3:0] logicRegCode,
    input       logicRegEnable,
    input       pdSupportEnable,
    input [3:0] modulationDepthCode,
    input       driverOverride
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // cycles since the carrier last changed state
    logic [4:0] quiet;
    always_ff @(posedge ref_clk)
        quiet <= (reset || $changed(modulated)) ? 5'h00 : quiet + 5'(quiet != 5'h1f);
    sequence supWr; regWrite && regAddr == 4'h0; endsequence
    sequence depWr; regWrite && regAddr == 4'h2; endsequence
    enable_follow_a: assert property (supWr |-> ##2 regEnable == $past(regWdata[0], 2))
        else $error("enable lost");
    supply_mode_a: assert property (supWr |-> ##2 lowSupplyModeSel == $past(regWdata[1], 2))
        else $error("supply mode lost");
    logic_off_a: assert property (supWr ##0 regWdata[2] |-> ##2 !logicRegEnable)
        else $error("logic regulator on");
    pd_support_a: assert property (pdSupportEnable == !(regEnable || lowSupplyModeSel))
        else $error("bad pd support");
    fixed_code_a: assert property (!lowSupplyModeSel |-> {analogRegCode, logicRegCode} == 8'hff)
        else $error("bad fixed code");
    common_code_a: assert property (lowSupplyModeSel |-> {analogRegCode, logicRegCode} == {2{txRegCode}})
        else $error("bad common code");
    depth_follow_a: assert property (depWr |-> ##2 modulationDepthCode == $past(regWdata[3:0], 2))
        else $error("bad depth");
    shaping_end_a: assert property (quiet > 5'h0d |-> !driverOverride)
        else $error("late override");
endmodule // tsc_props
bind tsc_supply_ctrl tsc_props tsc_props_inst (.ref_clk, .reset, .regAddr, .regWdata, .regWrite, .modulated,
    .regEnable, .lowSupplyModeSel, .txRegCode, .analogRegCode, .logicRegCode, .logicRegEnable,
    .pdSupportEnable, .modulationDepthCode, .driverOverride);

// file: tb_tx_supply_and_shaping_ctrl.sv
module tb_tx_supply_and_shaping_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
    logic       ref_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic       modulated = 1'b0, adjReq = 1'b0, limitOn = 1'b0;
    logic [3:0] regAddr = 4'h0, adjCode = 4'h0;
    logic [7:0] regWdata = 8'h00;
    wire  [7:0] regRdata;
    wire  [3:0] autoCode, txRegCode, analogRegCode, logicRegCode, modulationDepthCode;
    wire  [1:0] driverOverrideMode;
    wire        autoValid, currentLimit, regEnable, lowSupplyModeSel, logicRegEnable, pdSupportEnable, driverOverride;
    int         fail_count = 0, tests_run = 0, cycles = 0;
    // clock and hang guard
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            complete_run();
        end
    end
    tsc_supply_ctrl tsc_supply_ctrl_inst (.ref_clk, .reset, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .autoValid, .autoCode, .currentLimit, .modulated, .regEnable, .lowSupplyModeSel, .txRegCode,
        .analogRegCode, .logicRegCode, .logicRegEnable, .pdSupportEnable, .modulationDepthCode,
        .driverOverride, .driverOverrideMode);
    tsc_analog_model tsc_analog_model_inst (.ref_clk, .adjReq, .adjCode, .limitOn, .autoValid, .autoCode,
        .currentLimit);
    // one-cycle register write, then let the outputs settle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    // one-cycle read, data checked in the following cycle
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 `CHK(regRdata, e)
    endtask
    // flip the carrier and record the override over the next cycles
    task automatic shape(input logic [13:0] p, input logic [1:0] m, input logic lvl);
        logic [19:0] r;
        @(posedge ref_clk);
        modulated <= lvl;
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            #1 r[i] = driverOverride;
            if (driverOverride === 1'b1) `CHK(driverOverrideMode, m)
        end
        `CHK(r, 20'(p))
    endtask
    // rise, fall, rise again: the second rise must start the pattern over
    task automatic restart(input logic [13:0] p);
        logic [19:0] r;
        @(posedge ref_clk);
        modulated <= 1'b1;
        repeat (2) @(posedge ref_clk);
        modulated <= 1'b0;
        @(posedge ref_clk);
        modulated <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            #1 r[i] = driverOverride;
        end
        `CHK(r, 20'(p))
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        #1 `CHK({pdSupportEnable, analogRegCode, logicRegCode}, 9'h1ff)
        rdc(4'h0, 8'h00);
        rdc(4'h1, 8'h00);
        rdc(4'h9, 8'h00);
        $display("reset test done");
        wr(4'h0, 8'h01);
        `CHK({regEnable, pdSupportEnable, lowSupplyModeSel}, 3'h4)
        wr(4'h0, 8'h07);
        `CHK({pdSupportEnable, lowSupplyModeSel, logicRegEnable}, 3'h2)
        wr(4'h0, 8'h00);
        `CHK({regEnable, pdSupportEnable}, 2'h1)
        $display("supply test done");
        wr(4'h0, 8'h03);
        wr(4'h1, 8'h1a);
        `CHK({txRegCode, logicRegCode}, 8'haa)
        rdc(4'h8, 8'h0a);
        wr(4'h1, 8'h00);
        adjCode <= 4'h6;
        adjReq <= 1'b1;
        limitOn <= 1'b1;
        @(posedge ref_clk);
        adjReq <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rdc(4'h8, 8'h16);
        limitOn <= 1'b0;
        $display("regulator test done");
        for (int v = 0; v < 16; v += 5) begin
            wr(4'h2, 8'(v));
            `CHK(modulationDepthCode, 4'(v))
        end
        wr(4'h3, 8'h55);
        wr(4'h4, 8'h2a);
        wr(4'h6, 8'h0f);
        wr(4'h7, 8'h30);
        rdc(4'h7, 8'h30);
        for (int m = 0; m < 3; m++) begin
            wr(4'h5, 8'(m * 17));
            shape(14'h300f, 2'(m), 1'b1);
            shape(14'h2a55, 2'(m), 1'b0);
        end
        rdc(4'h5, 8'h22);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h00);
        shape(14'h300f, 2'h2, 1'b1);
        shape(14'h0000, 2'h2, 1'b0);
        restart(14'h300f);
        $display("shaping test done");
        complete_run();
    end
endmodule // tb_tx_supply_and_shaping_ctrl
